//--- dac_ctrl_pkg.sv
// constants, field layouts and carrier types of the dac control bank
package dac_ctrl_pkg;

  // ****************************************************************
  // control word carrier
  // ****************************************************************
  localparam int INDEX_W = 7;
  localparam int DATA_W  = 8;

  typedef struct packed {
    logic               rw;     // 0 write, 1 read
    logic [INDEX_W-1:0] index;  // register index
    logic [DATA_W-1:0]  data;   // register payload
  } ctrl_word_t;

  localparam logic RW_WRITE = 1'h0;
  localparam logic RW_READ  = 1'h1;

  // ****************************************************************
  // register indices and reset values
  // ****************************************************************
  localparam logic [INDEX_W-1:0] IDX_FIRST        = 7'h01;
  localparam logic [INDEX_W-1:0] IDX_FORMAT_CLOCK = 7'h09;
  localparam logic [INDEX_W-1:0] IDX_DEEMPH_PHASE = 7'h0A;
  localparam logic [INDEX_W-1:0] IDX_READBACK     = 7'h0B;
  localparam logic [INDEX_W-1:0] IDX_USER_OVER    = 7'h0C;

  localparam logic [DATA_W-1:0] RST_FORMAT_CLOCK = 8'h00;
  localparam logic [DATA_W-1:0] RST_DEEMPH_PHASE = 8'h00;
  localparam logic [DATA_W-1:0] RST_READBACK     = 8'h01;
  localparam logic [DATA_W-1:0] RST_USER_OVER    = 8'h00;

  // writable bits; reserved bits read as zero
  localparam logic [DATA_W-1:0] MASK_FORMAT_CLOCK = 8'h3F;
  localparam logic [DATA_W-1:0] MASK_DEEMPH_PHASE = 8'h3F;
  localparam logic [DATA_W-1:0] MASK_READBACK     = 8'hFF;
  localparam logic [DATA_W-1:0] MASK_USER_OVER    = 8'hFF;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int POS_ROLL_OFF    = 5;
  localparam int POS_HALF_RATE   = 4;
  localparam int POS_CLK_DISABLE = 3;
  localparam int POS_FMT_LO      = 0;
  localparam int POS_INVERT      = 5;
  localparam int POS_DMF_LO      = 3;
  localparam int POS_DM_LO       = 0;
  localparam int POS_SEQ_READ    = 7;
  localparam int POS_IDX_LO      = 0;
  localparam int POS_OVER        = 7;
  localparam int POS_USER_SEL    = 6;
  localparam int POS_USER_LO     = 0;

  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [2:0] FMT_RJ24 = 3'h0;
  localparam logic [2:0] FMT_RJ20 = 3'h1;
  localparam logic [2:0] FMT_RJ18 = 3'h2;
  localparam logic [2:0] FMT_RJ16 = 3'h3;
  localparam logic [2:0] FMT_I2S  = 3'h4;
  localparam logic [2:0] FMT_LJ   = 3'h5;
  localparam logic [4:0] BITS_24  = 5'h18;
  localparam logic [4:0] BITS_20  = 5'h14;
  localparam logic [4:0] BITS_18  = 5'h12;
  localparam logic [4:0] BITS_16  = 5'h10;
  localparam logic [1:0] DMF_44K1 = 2'h0;
  localparam logic [1:0] DMF_48K  = 2'h1;
  localparam logic [1:0] DMF_32K  = 2'h2;
  localparam logic [7:0] OSR_32   = 8'h20;
  localparam logic [7:0] OSR_64   = 8'h40;
  localparam logic [7:0] OSR_128  = 8'h80;
  localparam int         ZERO_RUN = 1024;

  typedef struct packed {
    logic       right_justified;
    logic       i2s;
    logic       left_justified;
    logic       reserved;
    logic [4:0] rj_bits;
  } fmt_decode_t;

  typedef struct packed {
    logic       rate_44k1;
    logic       rate_48k;
    logic       rate_32k;
    logic [2:0] pair_enable;  // pair 1 in bit 0
  } deemph_t;

endpackage : dac_ctrl_pkg

//--- sysclk_out_gen.sv
// system clock output: full or half rate, with output enable
`timescale 1ns/1ps
`default_nettype none
module sysclk_out_gen (
  input  wire logic core_clk,    // system clock
  input  wire logic nrst,        // async reset, active low
  input  wire logic half_rate,   // 1 selects half rate
  input  wire logic out_disable, // 1 releases the pin
  output var  logic pin_out,     // clock to the pin
  output var  logic pin_oe       // pin drive enable
);
  logic div_reg;

  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      div_reg <= 1'h0;
    else
      div_reg <= ~div_reg;

  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      pin_oe <= 1'h1;
    else
      pin_oe <= ~out_disable;

  // full rate has to pass the clock itself; no flop can toggle that fast
  always_comb
    pin_out = half_rate ? div_reg : core_clk;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_half_rate_toggles: assert property (
    half_rate ##1 half_rate |-> pin_out != $past(pin_out))
    else $error("half rate divider did not toggle");
  a_oe_follows_bit: assert property (
    $stable(out_disable)[*2] |-> pin_oe == !out_disable)
    else $error("clock output enable wrong");
endmodule : sysclk_out_gen
`default_nettype wire

//--- zero_flag_detect.sv
// per-channel zero run detection, counted in sample periods
`timescale 1ns/1ps
`default_nettype none
module zero_flag_detect #(
  parameter int CHANNELS = 6,
  parameter int RUN      = dac_ctrl_pkg::ZERO_RUN
) (
  input  wire logic                core_clk,      // system clock
  input  wire logic                nrst,          // async reset, active low
  input  wire logic                sample_strobe, // one pulse per sample
  input  wire logic [CHANNELS-1:0] zero_sample,   // channel sample is zero
  input  wire logic                block_detect,  // phase inversion active
  output var  logic [CHANNELS-1:0] zero_flags     // run of zeros seen
);
  localparam int CW = $clog2(RUN + 1);
  localparam logic [CW-1:0] RUN_C = CW'(RUN);
  localparam logic [CW-1:0] ONE_C = CW'(1);

  logic [CW-1:0] run_reg [CHANNELS];

  for (genvar c = 0; c < CHANNELS; c++)
  begin : g_ch
    always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
        run_reg[c] <= '0;
      else if (block_detect)
        run_reg[c] <= '0;
      else if (sample_strobe)
      begin
        if (!zero_sample[c])
          run_reg[c] <= '0;
        else if (run_reg[c] != RUN_C)
          run_reg[c] <= run_reg[c] + ONE_C;
      end

    always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
        zero_flags[c] <= 1'h0;
      else
        zero_flags[c] <= !block_detect && run_reg[c] == RUN_C;

    a_flag_needs_run: assert property (@(posedge core_clk)
      disable iff (!nrst)
      zero_flags[c] |-> $past(run_reg[c]) == RUN_C)
      else $error("zero flag set before full run");
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_invert_kills_flags: assert property (
    block_detect |=> zero_flags == '0)
    else $error("zero flag shown during inversion");
endmodule : zero_flag_detect
`default_nettype wire

//--- dac_mode_control_registers.sv
// control register bank of the six-channel dac: mode, clock, readback
`timescale 1ns/1ps
`default_nettype none
// How it works
// - divide bit picks full or half clock
// - disable bit releases clock output pin
// - codes 0-3 select right-justified 24/20/18/16
// - code 4 i2s, 5 left-justified
// - two bits choose de-emphasis sample rate
// - one de-emphasis enable per input pair
// - invert bit flips all six outputs
// - inversion disables zero mute and flags
// - sequential bit selects auto-increment readback
// - read index resets to one
// - auto-increment read ends at index
// - user select drives written pin levels
// - otherwise pins show zero flags
// - oversample bit doubles ratio per rate
// - top word bit chooses write or read
// - zero flag after 1024 zero samples
module dac_mode_control_registers
  import dac_ctrl_pkg::*;
#(
  parameter int CHANNELS = 6,
  parameter int ZERO_RUN_LEN = dac_ctrl_pkg::ZERO_RUN
) (
  input  wire logic                       core_clk,       // system clock
  input  wire logic                       nrst,           // reset, low
  input  wire logic                       ctrl_valid,     // word pulse
  input  wire dac_ctrl_pkg::ctrl_word_t   ctrl_word,      // control word
  input  wire logic                       fs_above_96k,   // high fs
  input  wire logic                       sample_strobe,  // sample tick
  input  wire logic [CHANNELS-1:0]        zero_sample,    // zero data
  output var  logic                       read_valid,     // read pulse
  output var  dac_ctrl_pkg::ctrl_word_t   read_word,      // read answer
  output var  dac_ctrl_pkg::fmt_decode_t  format_info,    // audio format
  output var  dac_ctrl_pkg::deemph_t      deemph_info,    // de-emphasis
  output var  logic                       phase_invert,   // invert all
  output var  logic                       roll_off_slow,  // filter pick
  output var  logic [7:0]                 oversample_ratio, // total osr
  output var  logic [CHANNELS-1:0]        zero_mute_req,  // mute request
  output var  logic [CHANNELS-1:0]        shared_pins,    // flag/user
  output var  logic                       sysclk_out_pin, // clock out
  output var  logic                       sysclk_out_oe   // clock oe
);
  import dac_ctrl_pkg::*;

  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [DATA_W-1:0] fmt_clk_reg;
  logic [DATA_W-1:0] deemph_reg;
  logic [DATA_W-1:0] readback_reg;
  logic [DATA_W-1:0] user_reg;
  logic [CHANNELS-1:0] zero_flags;

  logic              is_write;
  logic              is_read;
  logic [2:0]        audio_format_select;
  logic [1:0]        deemph_rate_select;
  logic              user_output_select;
  logic [5:0]        user_output_level;
  logic              seq_read_enable;
  logic [INDEX_W-1:0] register_index_field;
  logic              clock_out_half_rate;
  logic              clock_out_disable;

  always_comb
  begin
    is_write = ctrl_valid && ctrl_word.rw == RW_WRITE;
    is_read  = ctrl_valid && ctrl_word.rw == RW_READ;
  end

  function automatic logic [DATA_W-1:0] merge_write(
    input logic [INDEX_W-1:0] idx,
    input logic [DATA_W-1:0]  old,
    input logic [DATA_W-1:0]  mask,
    input logic [INDEX_W-1:0] target
  );
    if (idx == target)
      return ctrl_word.data & mask;
    return old;
  endfunction : merge_write

  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      fmt_clk_reg <= RST_FORMAT_CLOCK;
    else if (is_write)
      fmt_clk_reg <= merge_write(ctrl_word.index, fmt_clk_reg,
                                 MASK_FORMAT_CLOCK, IDX_FORMAT_CLOCK);

  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      deemph_reg <= RST_DEEMPH_PHASE;
    else if (is_write)
      deemph_reg <= merge_write(ctrl_word.index, deemph_reg,
                                MASK_DEEMPH_PHASE, IDX_DEEMPH_PHASE);

  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      readback_reg <= RST_READBACK;
    else if (is_write)
      readback_reg <= merge_write(ctrl_word.index, readback_reg,
                                  MASK_READBACK, IDX_READBACK);

  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      user_reg <= RST_USER_OVER;
    else if (is_write)
      user_reg <= merge_write(ctrl_word.index, user_reg,
                              MASK_USER_OVER, IDX_USER_OVER);

  // ****************************************************************
  // field extraction
  // ****************************************************************
  always_comb
  begin
    audio_format_select  = fmt_clk_reg[POS_FMT_LO +: 3];
    clock_out_half_rate  = fmt_clk_reg[POS_HALF_RATE];
    clock_out_disable    = fmt_clk_reg[POS_CLK_DISABLE];
    deemph_rate_select   = deemph_reg[POS_DMF_LO +: 2];
    seq_read_enable      = readback_reg[POS_SEQ_READ];
    register_index_field = readback_reg[POS_IDX_LO +: INDEX_W];
    user_output_select   = user_reg[POS_USER_SEL];
    user_output_level    = user_reg[POS_USER_LO +: 6];
  end

  function automatic fmt_decode_t decode_format(input logic [2:0] code);
    fmt_decode_t d;
    d = '0;
    case (code)
      FMT_RJ24: d.rj_bits = BITS_24;
      FMT_RJ20: d.rj_bits = BITS_20;
      FMT_RJ18: d.rj_bits = BITS_18;
      FMT_RJ16: d.rj_bits = BITS_16;
      FMT_I2S:  d.i2s = 1'h1;
      FMT_LJ:   d.left_justified = 1'h1;
      default:  d.reserved = 1'h1;
    endcase
    d.right_justified = d.rj_bits != '0;
    return d;
  endfunction : decode_format

  // ****************************************************************
  // decoded mode outputs
  // ****************************************************************
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      format_info <= decode_format(RST_FORMAT_CLOCK[POS_FMT_LO +: 3]);
    else
      format_info <= decode_format(audio_format_select);

  // a reserved rate code leaves all three curves off
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      deemph_info <= '0;
    else
    begin
      deemph_info.rate_44k1   <= deemph_rate_select == DMF_44K1;
      deemph_info.rate_48k    <= deemph_rate_select == DMF_48K;
      deemph_info.rate_32k    <= deemph_rate_select == DMF_32K;
      deemph_info.pair_enable <= deemph_reg[POS_DM_LO +: 3];
    end

  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      phase_invert <= 1'h0;
    else
      phase_invert <= deemph_reg[POS_INVERT];

  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      roll_off_slow <= 1'h0;
    else
      roll_off_slow <= fmt_clk_reg[POS_ROLL_OFF];

  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      oversample_ratio <= OSR_64;
    else if (user_reg[POS_OVER])
      oversample_ratio <= fs_above_96k ? OSR_64 : OSR_128;
    else
      oversample_ratio <= fs_above_96k ? OSR_32 : OSR_64;

  // ****************************************************************
  // zero flags and shared pins
  // ****************************************************************
  zero_flag_detect #(
    .CHANNELS (CHANNELS),
    .RUN      (ZERO_RUN_LEN)
  ) u_zero (
    .core_clk      (core_clk),
    .nrst          (nrst),
    .sample_strobe (sample_strobe),
    .zero_sample   (zero_sample),
    .block_detect  (deemph_reg[POS_INVERT]),
    .zero_flags    (zero_flags)
  );

  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      zero_mute_req <= '0;
    else
      zero_mute_req <= deemph_reg[POS_INVERT] ? '0 : zero_flags;

  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      shared_pins <= '0;
    else if (user_output_select)
      shared_pins <= user_output_level;
    else
      shared_pins <= zero_flags;

  sysclk_out_gen u_sysclk (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .half_rate   (clock_out_half_rate),
    .out_disable (clock_out_disable),
    .pin_out     (sysclk_out_pin),
    .pin_oe      (sysclk_out_oe)
  );

  // ****************************************************************
  // readback
  // ****************************************************************
  typedef enum logic {RB_IDLE, RB_SEQ} rb_state_t;
  rb_state_t          rb_state_reg;
  logic [INDEX_W-1:0] rb_cur_reg;

  function automatic logic [DATA_W-1:0] reg_lookup(
    input logic [INDEX_W-1:0] idx
  );
    if (idx == IDX_FORMAT_CLOCK)
      return fmt_clk_reg;
    else if (idx == IDX_DEEMPH_PHASE)
      return deemph_reg;
    else if (idx == IDX_READBACK)
      return readback_reg;
    else if (idx == IDX_USER_OVER)
      return user_reg;
    else
      return '0;
  endfunction : reg_lookup

  // reads arriving while a sequence runs are dropped
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      rb_state_reg <= RB_IDLE;
    else
      case (rb_state_reg)
        RB_IDLE:
          if (is_read && seq_read_enable &&
              register_index_field > IDX_FIRST)
            rb_state_reg <= RB_SEQ;
        RB_SEQ:
          if (rb_cur_reg >= register_index_field)
            rb_state_reg <= RB_IDLE;
        default:
          rb_state_reg <= RB_IDLE;
      endcase

  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      rb_cur_reg <= IDX_FIRST;
    else if (rb_state_reg == RB_IDLE)
      rb_cur_reg <= IDX_FIRST + IDX_FIRST;
    else
      rb_cur_reg <= rb_cur_reg + IDX_FIRST;

  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      read_valid <= 1'h0;
      read_word  <= '0;
    end
    else if (rb_state_reg == RB_SEQ)
    begin
      read_valid <= 1'h1;
      read_word  <= '{RW_READ, rb_cur_reg, reg_lookup(rb_cur_reg)};
    end
    else if (is_read && seq_read_enable)
    begin
      read_valid <= 1'h1;
      read_word  <= '{RW_READ, IDX_FIRST, reg_lookup(IDX_FIRST)};
    end
    else if (is_read)
    begin
      read_valid <= 1'h1;
      read_word  <= '{RW_READ, register_index_field,
                      reg_lookup(register_index_field)};
    end
    else
      read_valid <= 1'h0;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_single_read;
    rb_state_reg == RB_IDLE && is_read && !seq_read_enable;
  endsequence

  sequence s_seq_last;
    rb_state_reg == RB_SEQ && rb_cur_reg >= register_index_field;
  endsequence

  a_single_read_idx: assert property (
    s_single_read |=> read_valid && read_word.index ==
      $past(register_index_field))
    else $error("single read returned wrong index");
  a_seq_stops_last: assert property (
    s_seq_last ##1 !is_read |=> !read_valid)
    else $error("sequential read ran past last index");
  a_seq_starts_first: assert property (
    rb_state_reg == RB_IDLE && is_read && seq_read_enable
      |=> read_valid && read_word.index == IDX_FIRST)
    else $error("sequential read did not start at first");
  a_write_then_read: assert property (
    is_write && ctrl_word.index == IDX_USER_OVER
      |=> user_reg == ($past(ctrl_word.data) & MASK_USER_OVER))
    else $error("written value not held");
  a_read_no_write: assert property (
    is_read |=> $stable(deemph_reg) && $stable(user_reg))
    else $error("read request changed a register");
  a_user_pins_drive: assert property (
    user_output_select |=> shared_pins == $past(user_output_level))
    else $error("user level not on pins");
  a_flag_pins_show: assert property (
    !user_output_select |=> shared_pins == $past(zero_flags))
    else $error("zero flags not on pins");
  a_osr_high_bit: assert property (
    user_reg[POS_OVER] && !fs_above_96k |=> oversample_ratio == OSR_128)
    else $error("oversample ratio wrong");
  a_invert_no_mute: assert property (
    deemph_reg[POS_INVERT] |=> zero_mute_req == '0)
    else $error("zero mute during inversion");
  a_fmt_i2s_decode: assert property (
    audio_format_select == FMT_I2S |=> format_info.i2s &&
      !format_info.right_justified)
    else $error("i2s format not decoded");
endmodule : dac_mode_control_registers
`default_nettype wire

//--- dac_host_model.sv
// host model of the serial control port: issues words, keeps answers
`timescale 1ns/1ps
`default_nettype none
module dac_host_model
  import dac_ctrl_pkg::*;
(
  input  wire logic                     core_clk,   // system clock
  output var  logic                     ctrl_valid, // word strobe
  output var  dac_ctrl_pkg::ctrl_word_t ctrl_word,  // word to device
  input  wire logic                     read_valid, // answer strobe
  input  wire dac_ctrl_pkg::ctrl_word_t read_word   // answer word
);
  ctrl_word_t rx_q[$];

  initial
  begin
    ctrl_valid = 1'b0;
    ctrl_word  = '0;
  end

  // released bus shows the inverse so a late sample never sees a copy
  task automatic send(input logic rw, input logic [6:0] idx,
                      input logic [7:0] v);
    @(posedge core_clk);
    ctrl_valid <= 1'b1;
    ctrl_word  <= {rw, idx, v};
    @(posedge core_clk);
    ctrl_valid <= 1'b0;
    ctrl_word  <= ~{rw, idx, v};
  endtask : send

  always @(posedge core_clk)
  begin
    if (read_valid === 1'b1)
    begin
      rx_q.push_back(read_word);
    end
  end
endmodule : dac_host_model
`default_nettype wire

//--- tb_dac_mode_control_registers.sv
// self-checking testbench of the dac control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_dac_mode_control_registers;
  import dac_ctrl_pkg::*;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  localparam int ZR = 4;
  logic        core_clk, nrst, fs_above_96k, sample_strobe, ctrl_valid;
  logic        read_valid, phase_invert, roll_off_slow;
  logic        sysclk_out_pin, sysclk_out_oe;
  logic [5:0]  zero_sample, zero_mute_req, shared_pins;
  logic [7:0]  oversample_ratio, r, d;
  ctrl_word_t  ctrl_word, read_word;
  fmt_decode_t format_info;
  deemph_t     deemph_info;
  logic [31:0] lfsr = 32'h0001145C;
  int          err_count = 0;
  int          n_checks = 0;

  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  dac_mode_control_registers #(.CHANNELS(6), .ZERO_RUN_LEN(ZR)) i_dut (
    .core_clk(core_clk), .nrst(nrst), .ctrl_valid(ctrl_valid),
    .ctrl_word(ctrl_word), .fs_above_96k(fs_above_96k),
    .sample_strobe(sample_strobe), .zero_sample(zero_sample),
    .read_valid(read_valid), .read_word(read_word),
    .format_info(format_info), .deemph_info(deemph_info),
    .phase_invert(phase_invert), .roll_off_slow(roll_off_slow),
    .oversample_ratio(oversample_ratio), .zero_mute_req(zero_mute_req),
    .shared_pins(shared_pins), .sysclk_out_pin(sysclk_out_pin),
    .sysclk_out_oe(sysclk_out_oe));

  dac_host_model i_host (.core_clk(core_clk), .ctrl_valid(ctrl_valid),
    .ctrl_word(ctrl_word), .read_valid(read_valid), .read_word(read_word));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd

  function automatic logic [7:0] osr(input logic over, input logic hi);
    if (hi)
      return over ? OSR_64 : OSR_32;
    return over ? OSR_128 : OSR_64;
  endfunction : osr

  function automatic logic [4:0] rj_bits(input logic [1:0] c);
    return (c == 2'h0) ? BITS_24 : (c == 2'h1) ? BITS_20 :
           (c == 2'h2) ? BITS_18 : BITS_16;
  endfunction : rj_bits

  task automatic end_sim();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (i_host.rx_q.size() < n && k < 40)
    begin
      @(posedge core_clk);
      k++;
    end
    if (i_host.rx_q.size() < n)
    begin
      err_count++;
      end_sim();
    end
  endtask : wait_rx

  task automatic wr(input logic [6:0] idx, input logic [7:0] v);
    i_host.send(RW_WRITE, idx, v);
    repeat (3) @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [6:0] idx, output logic [7:0] v);
    i_host.rx_q.delete();
    i_host.send(RW_WRITE, IDX_READBACK, {1'b0, idx});
    i_host.send(RW_READ, idx, 8'h00);
    wait_rx(1);
    chk(i_host.rx_q[0].index, idx);
    v = i_host.rx_q[0].data;
  endtask : rd

  task automatic strb(input logic [5:0] z);
    @(posedge core_clk);
    sample_strobe <= 1'b1;
    zero_sample   <= z;
    @(posedge core_clk);
    sample_strobe <= 1'b0;
  endtask : strb

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    nrst = 1'b0;
    fs_above_96k = 1'b0;
    sample_strobe = 1'b0;
    zero_sample = 6'h00;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(oversample_ratio, OSR_64);
    chk(sysclk_out_oe, 1'b1);
    chk({format_info.right_justified, format_info.rj_bits}, {1'b1, BITS_24});
    chk(deemph_info, 6'h20);
    chk(phase_invert, 1'b0);
    i_host.send(RW_READ, 7'h00, 8'h00);
    wait_rx(1);
    chk(i_host.rx_q[0].index, IDX_FIRST);
    rd(IDX_FORMAT_CLOCK, d);
    chk(d, RST_FORMAT_CLOCK);
    rd(IDX_DEEMPH_PHASE, d);
    chk(d, RST_DEEMPH_PHASE);
    rd(IDX_USER_OVER, d);
    chk(d, RST_USER_OVER);
    // reserved format codes stay unwritten
    for (int c = 0; c < 6; c++)
    begin
      r = (rnd() & 8'h38) | 8'(c);
      wr(IDX_FORMAT_CLOCK, r);
      chk({format_info.right_justified, format_info.i2s,
           format_info.left_justified, format_info.reserved},
          {r[2:0] < 3'h4, r[2:0] == FMT_I2S, r[2:0] == FMT_LJ, 1'b0});
      if (r[2] == 1'b0)
        chk(format_info.rj_bits, rj_bits(r[1:0]));
      chk(sysclk_out_oe, !r[3]);
      chk(roll_off_slow, r[5]);
      rd(IDX_FORMAT_CLOCK, d);
      chk(d, r);
    end
    for (int k = 0; k < 8; k++)
    begin
      r = rnd() & 8'h3F;
      if (r[4:3] == 2'h3)
        r[3] = 1'b0;
      wr(IDX_DEEMPH_PHASE, r);
      chk(deemph_info, {r[4:3] == 2'h0, r[4:3] == 2'h1, r[4:3] == 2'h2,
                        r[2:0]});
      chk(phase_invert, r[5]);
      rd(IDX_DEEMPH_PHASE, d);
      chk(d, r);
    end
    for (int k = 0; k < 8; k++)
    begin
      r = rnd();
      fs_above_96k <= lfsr[9];
      wr(IDX_USER_OVER, r);
      chk(oversample_ratio, osr(r[7], fs_above_96k));
      chk(shared_pins, r[6] ? r[5:0] : 6'h00);
      rd(IDX_USER_OVER, d);
      chk(d, r);
    end
    i_host.send(RW_READ, IDX_USER_OVER, ~r);
    repeat (3) @(posedge core_clk);
    rd(IDX_USER_OVER, d);
    chk(d, r);
    wr(IDX_FORMAT_CLOCK, 8'h10);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge core_clk);
      #1 d[k] = sysclk_out_pin;
    end
    chk({d[0] ^ d[1], d[1] ^ d[2], d[2] ^ d[3]}, 3'h7);
    wr(IDX_FORMAT_CLOCK, 8'h00);
    @(posedge core_clk);
    #1 d[0] = sysclk_out_pin;
    @(negedge core_clk);
    #1 d[1] = sysclk_out_pin;
    chk(d[1:0], 2'h1);
    wr(IDX_USER_OVER, 8'h00);
    wr(IDX_DEEMPH_PHASE, 8'h00);
    // at least one channel must see the run, or the check cannot fail
    r = rnd() | 8'h01;
    strb(6'h00);
    repeat (ZR - 1) strb(r[5:0]);
    repeat (3) @(posedge core_clk);
    chk(shared_pins, 6'h00);
    strb(r[5:0]);
    repeat (3) @(posedge core_clk);
    chk(shared_pins, r[5:0]);
    chk(zero_mute_req, r[5:0]);
    wr(IDX_DEEMPH_PHASE, 8'h20);
    chk({zero_mute_req, shared_pins}, 12'h000);
    wr(IDX_READBACK, 8'h8C);
    i_host.rx_q.delete();
    i_host.send(RW_READ, IDX_FIRST, 8'h00);
    wait_rx(12);
    repeat (3) @(posedge core_clk);
    chk(16'(i_host.rx_q.size()), 16'h000C);
    chk(i_host.rx_q[11].index, IDX_USER_OVER);
    chk(i_host.rx_q[9].data, 8'h20);
    chk(i_host.rx_q[10].data, 8'h8C);
    end_sim();
  end
endmodule : tb_dac_mode_control_registers
`default_nettype wire
